// >>> design/tcco_cfg.svh
`ifndef TCCO_CFG_SVH
`define TCCO_CFG_SVH

// Register byte offsets
`define TCCO_CTRL_OFS 8'h00
`define TCCO_START_OFS 8'h04
`define TCCO_RELOAD_OFS 8'h08
`define TCCO_COUNT_OFS 8'h0C
`define TCCO_OUT_OFS 8'h10
`define TCCO_PRESC_OFS 8'h14

// Control register fields
`define TCCO_MODE_LSB 0
`define TCCO_MODE_MSB 2
`define TCCO_STINT_BIT 3
`define TCCO_CLKSEL_BIT 4
`define TCCO_FILT_BIT 5
`define TCCO_EDGE_LSB 6
`define TCCO_EDGE_MSB 7
`define TCCO_OMODE_BIT 8
`define TCCO_OPOL_BIT 9
`define TCCO_OEN_BIT 10
`define TCCO_CTRL_W 11

// Start register bits
`define TCCO_GO_BIT 0
`define TCCO_HALT_BIT 1

// Reset values and the one-count all-ones value
`define TCCO_CTRL_RST 11'h000
`define TCCO_RELOAD_RST 16'h0000
`define TCCO_PRESC_RST 16'h0000
`define TCCO_CNT_ALL1 16'hFFFF

// Bus responses
`define TCCO_RESP_OK 2'h0
`define TCCO_RESP_ERR 2'h2

`endif

// >>> design/tcco_pkg.sv
package tcco_pkg;

    // Counting modes as written to the control register
    typedef enum logic [2:0]
    {
        TCCO_INTERVAL = 3'b000,
        TCCO_CAPTURE = 3'b010,
        TCCO_EVENT = 3'b011,
        TCCO_ONECOUNT = 3'b100,
        TCCO_CAPONE = 3'b110
    } tcco_mode_e;

    // Channel sequencing states
    typedef enum logic [1:0]
    {
        TCCO_ST_STOP = 2'b00,
        TCCO_ST_FIRST = 2'b01,
        TCCO_ST_TRIG = 2'b10,
        TCCO_ST_RUN = 2'b11
    } tcco_state_e;

    // Valid input edge selection
    typedef enum logic [1:0]
    {
        TCCO_EDGE_FALL = 2'b00,
        TCCO_EDGE_RISE = 2'b01,
        TCCO_EDGE_BOTH = 2'b10
    } tcco_edge_e;

endpackage

// >>> design/tcco_channel.sv
// Overview of operation
// - Interval: after start, first count clock loads reload value, later clocks count down.
// - Interval: at zero, raise interrupt, reload and keep counting.
// - Interval/capture: start-interrupt select 1 raises interrupt at start trigger.
// - Event counter: start loads reload value at once, input edges count down.
// - Stopped channel holds counter, running flag 0; start sets running flag.
// - Capture: first count clock clears counter and starts counting up.
// - Capture: each valid edge copies counter, raises interrupt, counter restarts at zero.
// - One-count modes: start enters wait; input rising edge is start trigger.
// - One-count: trigger loads reload, count down; at zero interrupt, all ones, wait for next trigger.
// - Capture plus one-count: trigger clears counter and counts up.
// - Capture plus one-count: falling edge copies counter and raises interrupt.
// - Noise filter delays input edge detection by three operation clocks.
// - Operation clock enable, start trigger and interrupt are one-cycle pulses.
// - Master output mode ignores polarity; only own interrupt toggles output.
// - Slave mode: polarity 0 master sets, slave resets; polarity 1 swapped.
// - Simultaneous master and slave interrupts: reset wins, set masked.
// - Output enabled: only interrupts change the output, software writes ignored.
// - Output disabled: software writes accepted, interrupts not forwarded.
// - Output register readable at any time, shows current output level.
// - Counter changes one peripheral cycle after the count clock edge.
// - Master mode: every interrupt inverts output; the start event does so only with start-interrupt select 1.
// - Slave mode: master set is applied one count clock later.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "tcco_cfg.svh"

module tcco_channel
    import tcco_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer pins and neighbour channel
    input wire logic timer_input_pin,
    input wire logic master_interrupt_in,
    output logic channel_output_bit,
    // Channel events
    output logic channel_interrupt,
    output logic start_trigger,
    output logic op_clock_enable,
    output logic channel_running_flag
);

    // Software-visible state
    logic [`TCCO_CTRL_W-1:0] ctrl_q;
    logic [CNT_W-1:0] reload_q, reload_d;
    logic [CNT_W-1:0] presc_q;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic out_q, out_d;
    logic run_q;
    tcco_state_e st_q, st_d;

    // Bus bookkeeping
    logic aw_got_q, w_got_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // Timing and input path
    logic [CNT_W-1:0] div_q;
    logic tick_q;
    logic ti_s1_q, ti_s2_q, ti_s3_q, ti_lvl_q;
    logic nf1_q, nf2_q, nf_lvl_q, samp_q;
    logic cnt_en_q, rise_q, vedge_q, fall_q;
    logic int_q, int_d, strig_q, strig_d;
    logic pend_q;

    // Control field decode
    wire tcco_mode_e mode = tcco_mode_e'(ctrl_q[`TCCO_MODE_MSB:`TCCO_MODE_LSB]);
    wire st_int_sel = ctrl_q[`TCCO_STINT_BIT];
    wire clk_sel = ctrl_q[`TCCO_CLKSEL_BIT];
    wire filt_on = ctrl_q[`TCCO_FILT_BIT];
    wire tcco_edge_e edge_sel = tcco_edge_e'(ctrl_q[`TCCO_EDGE_MSB:`TCCO_EDGE_LSB]);
    wire out_mode = ctrl_q[`TCCO_OMODE_BIT];
    wire out_pol = ctrl_q[`TCCO_OPOL_BIT];
    wire out_en = ctrl_q[`TCCO_OEN_BIT];

    // Write decode; a write is committed once address and data are both held
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire wr_go = aw_got_q & w_got_q & ~bvalid_q;
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire sel_ctrl = waddr_q == `TCCO_CTRL_OFS;
    wire sel_start = waddr_q == `TCCO_START_OFS;
    wire sel_reload = waddr_q == `TCCO_RELOAD_OFS;
    wire sel_out = waddr_q == `TCCO_OUT_OFS;
    wire sel_presc = waddr_q == `TCCO_PRESC_OFS;
    wire wr_hit = sel_ctrl | sel_start | sel_reload | sel_out | sel_presc | (waddr_q == `TCCO_COUNT_OFS);
    wire [31:0] ctrl_m = (32'(ctrl_q) & ~wmask) | (wdata_q & wmask);
    wire [31:0] reload_m = (32'(reload_q) & ~wmask) | (wdata_q & wmask);
    wire [31:0] presc_m = (32'(presc_q) & ~wmask) | (wdata_q & wmask);
    wire go_wr = wr_go & sel_start & wstrb_q[0] & wdata_q[`TCCO_GO_BIT];
    wire halt_wr = wr_go & sel_start & wstrb_q[0] & wdata_q[`TCCO_HALT_BIT] & ~wdata_q[`TCCO_GO_BIT];
    wire out_wr = wr_go & sel_out & wstrb_q[0];

    // Read decode
    wire [7:0] ra = s_axi_araddr;
    wire rd_hit = ra == `TCCO_CTRL_OFS || ra == `TCCO_START_OFS || ra == `TCCO_RELOAD_OFS
        || ra == `TCCO_COUNT_OFS || ra == `TCCO_OUT_OFS || ra == `TCCO_PRESC_OFS;
    wire [31:0] rd_mux = (ra == `TCCO_CTRL_OFS) ? 32'(ctrl_q) :
        (ra == `TCCO_START_OFS) ? {30'h0, st_q == TCCO_ST_TRIG, run_q} :
        (ra == `TCCO_RELOAD_OFS) ? 32'(reload_q) :
        (ra == `TCCO_COUNT_OFS) ? 32'(cnt_q) :
        (ra == `TCCO_OUT_OFS) ? {31'h0, out_q} :
        (ra == `TCCO_PRESC_OFS) ? 32'(presc_q) : 32'h0000_0000;

    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready = ~w_got_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Write channel capture in either order, then one response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `TCCO_RESP_OK;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_got_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `TCCO_RESP_OK : `TCCO_RESP_ERR;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `TCCO_RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? `TCCO_RESP_OK : `TCCO_RESP_ERR;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // Configuration registers; count register is read only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= `TCCO_CTRL_RST;
            presc_q <= `TCCO_PRESC_RST;
        end
        else if (wr_go)
        begin
            if (sel_ctrl)
                ctrl_q <= ctrl_m[`TCCO_CTRL_W-1:0];
            if (sel_presc)
                presc_q <= presc_m[CNT_W-1:0];
        end
    end

    // Operation clock enable: one cycle high every presc_q+1 cycles
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= div_q == presc_q;
            div_q <= (div_q >= presc_q) ? '0 : div_q + 1'b1;
        end
    end
    assign op_clock_enable = tick_q;

    // Pin synchroniser; a level counts once stages two and three agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ti_s1_q <= 1'b0;
            ti_s2_q <= 1'b0;
            ti_s3_q <= 1'b0;
            ti_lvl_q <= 1'b0;
        end
        else
        begin
            ti_s1_q <= timer_input_pin;
            ti_s2_q <= ti_s1_q;
            ti_s3_q <= ti_s2_q;
            if (ti_s2_q == ti_s3_q)
                ti_lvl_q <= ti_s3_q;
        end
    end

    // Noise filter: level must hold two operation clocks before it is passed on
    wire filt_lvl = filt_on ? nf_lvl_q : ti_lvl_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            nf1_q <= 1'b0;
            nf2_q <= 1'b0;
            nf_lvl_q <= 1'b0;
            samp_q <= 1'b0;
        end
        else if (tick_q)
        begin
            nf1_q <= ti_lvl_q;
            nf2_q <= nf1_q;
            if (nf1_q == nf2_q)
                nf_lvl_q <= nf2_q;
            samp_q <= filt_lvl;
        end
    end

    // Edge detection on operation-clock sampling
    wire rise_p = tick_q & filt_lvl & ~samp_q;
    wire fall_p = tick_q & ~filt_lvl & samp_q;
    wire vedge_p = (edge_sel == TCCO_EDGE_RISE) ? rise_p :
        (edge_sel == TCCO_EDGE_BOTH) ? (rise_p | fall_p) : fall_p;
    wire count_clk = clk_sel ? vedge_p : tick_q;

    // One-cycle retiming so the counter moves a cycle after the count clock
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_en_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            vedge_q <= 1'b0;
        end
        else
        begin
            cnt_en_q <= count_clk;
            rise_q <= rise_p;
            fall_q <= fall_p;
            vedge_q <= vedge_p;
        end
    end

    // Counter sequencing per mode
    wire cnt_zero = cnt_q == '0;
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        reload_d = reload_q;
        int_d = 1'b0;
        strig_d = 1'b0;
        if (wr_go && sel_reload)
            reload_d = reload_m[CNT_W-1:0];
        if (halt_wr)
            st_d = TCCO_ST_STOP;
        else if (go_wr)
        begin
            unique case (mode)
                TCCO_EVENT:
                begin
                    cnt_d = reload_q;
                    st_d = TCCO_ST_RUN;
                end
                TCCO_ONECOUNT, TCCO_CAPONE: st_d = TCCO_ST_TRIG;
                default: st_d = TCCO_ST_FIRST;
            endcase
        end
        else
        begin
            unique case (st_q)
                TCCO_ST_STOP: st_d = TCCO_ST_STOP;
                TCCO_ST_FIRST:
                    if (cnt_en_q)
                    begin
                        strig_d = 1'b1;
                        int_d = st_int_sel;
                        cnt_d = (mode == TCCO_CAPTURE) ? '0 : reload_q;
                        st_d = TCCO_ST_RUN;
                    end
                TCCO_ST_TRIG:
                    if (rise_q)
                    begin
                        strig_d = 1'b1;
                        cnt_d = (mode == TCCO_CAPONE) ? '0 : reload_q;
                        st_d = TCCO_ST_RUN;
                    end
                TCCO_ST_RUN:
                    unique case (mode)
                        TCCO_CAPTURE:
                            if (vedge_q)
                            begin
                                reload_d = cnt_q;
                                int_d = 1'b1;
                                cnt_d = '0;
                            end
                            else if (cnt_en_q)
                                cnt_d = cnt_q + 1'b1;
                        TCCO_CAPONE:
                            if (fall_q)
                            begin
                                reload_d = cnt_q;
                                int_d = 1'b1;
                                st_d = TCCO_ST_TRIG;
                            end
                            else if (cnt_en_q)
                                cnt_d = cnt_q + 1'b1;
                        TCCO_ONECOUNT:
                            if (cnt_en_q && cnt_zero)
                            begin
                                int_d = 1'b1;
                                cnt_d = `TCCO_CNT_ALL1;
                                st_d = TCCO_ST_TRIG;
                            end
                            else if (cnt_en_q)
                                cnt_d = cnt_q - 1'b1;
                        default:
                        begin
                            // Event mode counts input edges, interval counts count clocks
                            if ((mode == TCCO_EVENT) ? vedge_q : cnt_en_q)
                            begin
                                if (cnt_zero)
                                begin
                                    int_d = 1'b1;
                                    cnt_d = reload_q;
                                end
                                else
                                    cnt_d = cnt_q - 1'b1;
                            end
                        end
                    endcase
            endcase
        end
    end

    // Sequencer registers; capture into the reload register wins over a bus write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= TCCO_ST_STOP;
            cnt_q <= '0;
            reload_q <= `TCCO_RELOAD_RST;
            int_q <= 1'b0;
            strig_q <= 1'b0;
            run_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            reload_q <= reload_d;
            int_q <= int_d;
            strig_q <= strig_d;
            run_q <= st_d != TCCO_ST_STOP;
        end
    end
    assign channel_interrupt = int_q;
    assign start_trigger = strig_q;
    assign channel_running_flag = run_q;

    // Output events; the master set waits one count clock so 0% and 100% are reachable
    // Start toggle rides on the start interrupt, so one-count triggers leave the output alone
    wire tgl_ev = out_en & ~out_mode & int_q;
    wire set_apply = out_en & out_mode & pend_q & cnt_en_q;
    wire rst_ev = out_en & out_mode & int_q;
    always_comb
    begin
        out_d = out_q;
        if (!out_en)
        begin
            if (out_wr)
                out_d = wdata_q[0];
        end
        else if (!out_mode)
        begin
            if (tgl_ev)
                out_d = ~out_q;
        end
        else if (rst_ev)
            out_d = out_pol;
        else if (set_apply)
            out_d = ~out_pol;
    end

    // Pending master set; cleared when applied, masked or output disabled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else
        begin
            out_q <= out_d;
            if (!out_en || !out_mode || rst_ev)
                pend_q <= 1'b0;
            else if (master_interrupt_in)
                pend_q <= 1'b1;
            else if (set_apply)
                pend_q <= 1'b0;
        end
    end
    assign channel_output_bit = out_q;

    // Checks
    start_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        start_trigger |=> !start_trigger) else $error("start trigger longer than one cycle");
    stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == TCCO_ST_STOP && !go_wr) |=> $stable(cnt_q) && !run_q) else $error("stopped counter moved");
    run_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        go_wr |=> channel_running_flag) else $error("running flag not set by start");
    event_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (go_wr && mode == TCCO_EVENT) |=> cnt_q == $past(reload_q)) else $error("event start did not load");
    intv_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == TCCO_ST_RUN && mode == TCCO_INTERVAL && cnt_en_q && cnt_zero && !wr_go)
        |=> cnt_q == $past(reload_q) && channel_interrupt) else $error("interval reload missed");
    cap_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == TCCO_ST_RUN && mode == TCCO_CAPTURE && vedge_q && !wr_go)
        |=> reload_q == $past(cnt_q) && cnt_q == '0 && channel_interrupt) else $error("capture failed");
    cap_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == TCCO_ST_FIRST && mode == TCCO_CAPTURE && cnt_en_q && !wr_go)
        |=> cnt_q == '0 && st_q == TCCO_ST_RUN ##1 !start_trigger) else $error("capture start wrong");
    one_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == TCCO_ST_RUN && mode == TCCO_ONECOUNT && cnt_en_q && cnt_zero && !wr_go)
        |=> cnt_q == `TCCO_CNT_ALL1 && st_q == TCCO_ST_TRIG) else $error("one-count end wrong");
    out_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (out_en && !tgl_ev && !rst_ev && !set_apply) |=> $stable(channel_output_bit))
        else $error("output changed without event");
    reset_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rst_ev && set_apply) |=> channel_output_bit == $past(out_pol)) else $error("set beat reset");
    cnt_lag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == TCCO_ST_RUN && mode == TCCO_INTERVAL && !cnt_en_q && !wr_go) |=> $stable(cnt_q))
        else $error("counter moved without count clock");
    intv_cov: cover property (@(posedge aclk) disable iff (!aresetn)
        st_q == TCCO_ST_RUN && mode == TCCO_INTERVAL && int_q);
    cap_cov: cover property (@(posedge aclk) disable iff (!aresetn)
        st_q == TCCO_ST_RUN && mode == TCCO_CAPONE && fall_q);
    pwm_cov: cover property (@(posedge aclk) disable iff (!aresetn) rst_ev && set_apply);

endmodule

// >>> bench/tcco_pin_model.sv
`timescale 1ns/1ps
module tcco_pin_model
(
    // Clock and command
    input wire logic aclk,
    input wire logic [7:0] pulse_len,
    input wire logic pulse_go,
    // Timer input level
    output logic pin
);
    logic [7:0] left_q = 8'h00;
    // High pulse of pulse_len cycles; idle low so every pulse gives one rise and one fall
    always_ff @(posedge aclk)
    begin
        if (pulse_go)
            left_q <= pulse_len;
        else if (left_q != 8'h00)
            left_q <= left_q - 8'h01;
    end
    assign pin = (left_q != 8'h00);
endmodule

// >>> bench/tcco_channel_bench.sv
`timescale 1ns/1ps
module tcco_channel_bench
    import tcco_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] s;} tcco_row_s;
    // Bus master, pin and neighbour drive
    logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, mi = 1'h0, go = 1'h0;
    logic [7:0] aa = 8'h00, ra = 8'h00, len = 8'h00;
    logic [31:0] wd = 32'h0, rdata, rd;
    logic awr, wrdy, bv, arr, rv, ob, irq, trg, opc, run, pin;
    logic [1:0] bresp, rresp, resp;
    int n_mismatch = 0, checks = 0, cyc = 0, nirq = 0, last = 0, gap = 0, n0 = 0, ntrg = 0, nopc = 0, t0 = 0;
    tcco_row_s rows [5] = '{{8'h00, 32'hFFFFFFFF, 32'h7FF, 2'h0}, {8'h08, 32'h1234ABCD, 32'hABCD, 2'h0},
        {8'h14, 32'hFFFF0007, 32'h7, 2'h0}, {8'h14, 32'h0, 32'h0, 2'h0}, {8'h18, 32'h1, 32'h0, 2'h2}};

    tcco_channel dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .timer_input_pin(pin), .master_interrupt_in(mi), .channel_output_bit(ob), .channel_interrupt(irq),
        .start_trigger(trg), .op_clock_enable(opc), .channel_running_flag(run));
    tcco_pin_model pin_u (.aclk(aclk), .pulse_len(len), .pulse_go(go), .pin(pin));

    always #12.5 aclk = ~aclk;
    // Interrupt count and spacing, sampled mid-cycle; run ceiling
    always @(negedge aclk)
    begin
        cyc <= cyc + 1;
        if (trg === 1'h1)
            ntrg <= ntrg + 1;
        if (opc === 1'h1)
            nopc <= nopc + 1;
        if (irq === 1'h1)
        begin
            nirq <= nirq + 1;
            gap <= cyc - last;
            last <= cyc;
        end
        if (cyc == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Handshakes judged at the falling edge, where the next rising edge will see the same values
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'h0;
        aa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        while (!tb)
        begin
            @(negedge aclk);
            ta = awv & awr;
            tw = wv & wrdy;
            tb = (bv === 1'h1);
            resp = bresp;
            @(posedge aclk);
            if (ta)
                awv <= 1'h0;
            if (tw)
                wv <= 1'h0;
        end
        br <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a);
        logic ta, tr;
        tr = 1'h0;
        ra <= a;
        arv <= 1'h1;
        rr <= 1'h1;
        while (!tr)
        begin
            @(negedge aclk);
            ta = arv & arr;
            tr = (rv === 1'h1);
            rd = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta)
                arv <= 1'h0;
        end
        rr <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic pulse(input logic [7:0] n);
        len <= n;
        go <= 1'h1;
        @(posedge aclk);
        go <= 1'h0;
        repeat (n + 12) @(posedge aclk);
    endtask
    task automatic mpulse();
        mi <= 1'h1;
        @(posedge aclk);
        mi <= 1'h0;
        repeat (5) @(posedge aclk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge aclk);
        cmp({ob, irq, trg, run, opc}, 32'h0);
        aresetn <= 1'h1;
        @(posedge aclk);
        $display("test reset done");
        // Register rows: write, then read back with response
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            cmp(resp, rows[i].s);
            rdr(rows[i].a);
            cmp(resp, rows[i].s);
            if (rows[i].s == 2'h0)
                cmp(rd, rows[i].r);
        end
        $display("test registers done");
        // Prescaler 3 gives one enable cycle in four
        wr(8'h14, 32'h3);
        n0 = nopc;
        repeat (40) @(posedge aclk);
        cmp(nopc - n0, 32'hA);
        wr(8'h14, 32'h0);
        $display("test prescaler done");
        // Interval, start interrupt, master toggle output
        wr(8'h08, 32'h3);
        wr(8'h00, 32'h408);
        n0 = nirq;
        wr(8'h04, 32'h1);
        cmp(run, 1'h1);
        for (int i = 0; i < 200 && nirq < n0 + 4; i++) @(posedge aclk);
        cmp(gap, 32'h4);
        wr(8'h04, 32'h2);
        repeat (4) @(posedge aclk);
        cmp(run, 1'h0);
        rdr(8'h10);
        cmp(rd[0], nirq[0]);
        $display("test interval done");
        // Event counter on both input edges
        wr(8'h08, 32'h5);
        // Both edges through the noise filter: each pulse counts twice
        wr(8'h00, 32'hA3);
        wr(8'h04, 32'h1);
        rdr(8'h0C);
        cmp(rd, 32'h5);
        pulse(8'h4);
        pulse(8'h4);
        rdr(8'h0C);
        cmp(rd, 32'h1);
        $display("test event done");
        // One-count: wait, trigger, count down, all ones
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h4);
        wr(8'h04, 32'h1);
        rdr(8'h04);
        cmp(rd[1:0], 2'h3);
        n0 = nirq;
        pulse(8'h4);
        cmp(nirq - n0, 32'h1);
        rdr(8'h0C);
        cmp(rd, 32'hFFFF);
        $display("test one-count done");
        // High width measurement; a fresh start, so this capture is genuine
        wr(8'h00, 32'h6);
        wr(8'h04, 32'h1);
        n0 = nirq;
        pulse(8'hA);
        cmp(nirq - n0, 32'h1);
        rdr(8'h08);
        cmp(rd >= 32'h8 && rd <= 32'hB, 1'h1);
        $display("test width done");
        // Pulse interval on rising edges, start interrupt on; rises come 17 clocks apart
        wr(8'h00, 32'h4A);
        n0 = nirq;
        t0 = ntrg;
        wr(8'h04, 32'h1);
        pulse(8'h4);
        cmp(nirq - n0, 32'h2);
        cmp(ntrg - t0, 32'h1);
        n0 = nirq;
        pulse(8'h4);
        cmp(nirq - n0, 32'h1);
        rdr(8'h08);
        cmp(rd, 32'h10);
        wr(8'h04, 32'h2);
        $display("test capture done");
        // Output bit: software write, then interrupt-only in slave mode
        wr(8'h08, 32'hFFFF);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h1);
        wr(8'h10, 32'h1);
        rdr(8'h10);
        cmp(rd[0], 1'h1);
        wr(8'h00, 32'h400);
        wr(8'h10, 32'h0);
        rdr(8'h10);
        cmp(rd[0], 1'h1);
        wr(8'h00, 32'h700);
        mpulse();
        cmp(ob, 1'h0);
        wr(8'h00, 32'h500);
        mpulse();
        cmp(ob, 1'h1);
        wr(8'h00, 32'h300);
        mpulse();
        cmp(ob, 1'h1);
        $display("test output done");
        // Reset while running clears outputs and control
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        cmp({ob, irq, trg, run, opc}, 32'h0);
        aresetn <= 1'h1;
        @(posedge aclk);
        rdr(8'h00);
        cmp(rd, 32'h0);
        $display("test reset again done");
        tally_and_finish();
    end
endmodule
